/* File: mds_pkg.sv */
// constants, operation codes and carriers of the multiply/divide/saturate datapath
// assumes the core decoder drives mds_req_t and reads mds_rsp_t on the same clock
package mds_pkg;

   // operation codes issued by the decoder
   typedef enum logic [4:0] {
      OP_DUAL_ADD = 5'h00,
      OP_DUAL_SUB = 5'h01,
      OP_HALF_MUL = 5'h02,
      OP_WORD_MUL = 5'h03,
      OP_ULONG_MUL = 5'h04,
      OP_ULONG_MAC = 5'h05,
      OP_SLONG_MUL = 5'h06,
      OP_SLONG_MAC = 5'h07,
      OP_SIGN_DIV = 5'h08,
      OP_UNS_DIV = 5'h09,
      OP_SIGN_SAT = 5'h0A,
      OP_UNS_SAT = 5'h0B,
      OP_SAT_ADD = 5'h0C,
      OP_QSUB = 5'h0D,
      OP_SAT_DADD = 5'h0E,
      OP_QDSUB = 5'h0F,
      OP_QADD16 = 5'h10,
      OP_QSUB16 = 5'h11,
      OP_QADD8 = 5'h12,
      OP_QSUB8 = 5'h13,
      OP_QASX = 5'h14,
      OP_QSAX = 5'h15
   } mds_op_t;

   // one issued operation
   typedef struct packed {
      mds_op_t op;
      logic xchg;        // swap halfwords of b (dual ops)
      logic selN;        // 1 = top halfword of a
      logic selM;        // 1 = top halfword of b
      logic uns;         // unsigned lane saturation
      logic [5:0] satN;  // saturate bit position
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] accHi;
      logic [31:0] accLo;
   } mds_req_t;

   // one result for writeback
   typedef struct packed {
      logic [31:0] lo;
      logic [31:0] hi;
      logic wrHi;        // hi word is valid (long ops)
   } mds_rsp_t;

   // status register map
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam int Q_BIT = 0;
   localparam int BUSY_BIT = 1;
   localparam logic Q_RESET = 1'b0;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic [5:0] DIV_LAST = 6'h1F;
   localparam logic [5:0] HALF_BITS = 6'h10;
   localparam logic [5:0] BYTE_BITS = 6'h08;
   localparam logic [5:0] WORD_BITS = 6'h20;

   // state of the divider sequencer
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_DIV = 1'b1
   } mds_state_t;

endpackage : mds_pkg

/* File: mds_datapath.sv */
// multiply, divide and saturate datapath with sticky saturation flag
// assumes operands from the core register file on mclk; status over AHB-Lite
//
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps

// Summary of operation
// [RULE1] dual add overflow sets sticky flag
// [RULE2] dual products added or bottom minus top
// [RULE3] exchange swaps second operand halfwords
// [RULE4] halfword selectors pick bottom or top
// [RULE5] halfword product is signed 32 bits
// [RULE6] word by half keeps upper 32 bits
// [RULE7] long multiply splits 64-bit product
// [RULE8] unsigned long accumulate adds register pair
// [RULE9] signed long accumulate adds register pair
// [RULE10] long ops leave condition flags alone
// [RULE11] source gives distinct pair, no SP/PC
// [RULE12] divide rounds quotient towards zero
// [RULE13] divides leave condition flags alone
// [RULE14] signed saturation clamps to signed range
// [RULE15] unsigned saturation clamps to zero..max
// [RULE16] saturation sets sticky flag, else unchanged
// [RULE17] flag cleared only by status write
// [RULE18] saturating add/sub/exchange/double operations provided
// [RULE19] divide stalls issue, writes back once
// [RULE20] sticky flag resets zero and holds
module mds_datapath
   import mds_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic reqValid,
   output logic reqReady,
   input wire mds_pkg::mds_req_t req,
   output logic rspValid,
   output mds_pkg::mds_rsp_t rsp,
   output logic satFlag,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata
);
   import mds_pkg::*;

   mds_state_t state_reg;
   mds_req_t hold_reg;
   mds_rsp_t rsp_reg, rsp_next;
   logic rspValid_reg, q_reg, q_next, satHit;
   logic [32:0] divRem_reg;
   logic [31:0] divQuo_reg, divDen_reg;
   logic [5:0] divCnt_reg;
   logic divNeg_reg, divZero_reg;
   logic wrPend_reg, hitStat_reg;
   logic [31:0] hrdata_reg;

   // saturate a wide value to n bits, flag in bit 32
   function automatic logic [32:0] satv(input logic signed [35:0] v,
                                        input logic [5:0] n, input logic uns);
      logic signed [35:0] hi;
      logic signed [35:0] lo;
      logic signed [35:0] r;
      hi = uns ? (36'sh1 <<< n) - 36'sh1 : (36'sh1 <<< (n - 6'h1)) - 36'sh1; // RULE14
      lo = uns ? 36'sh0 : -(36'sh1 <<< (n - 6'h1)); // RULE15
      r = (v > hi) ? hi : ((v < lo) ? lo : v);
      satv = {r != v, r[31:0]}; // RULE16
   endfunction : satv

   // handshake and decode
   wire fire = ce & reqValid & reqReady;
   wire isDiv = (req.op == OP_SIGN_DIV) | (req.op == OP_UNS_DIV);
   wire sgnDiv = req.op == OP_SIGN_DIV;
   wire [31:0] bx = req.xchg ? {req.b[15:0], req.b[31:16]} : req.b; // RULE3
   wire signed [15:0] hN = req.selN ? req.a[31:16] : req.a[15:0]; // RULE4
   wire signed [15:0] hM = req.selM ? req.b[31:16] : req.b[15:0]; // RULE4
   // product formed at full width so no tool truncates it to 16 bits
   wire signed [31:0] halfProd = hN * hM; // RULE5
   wire signed [31:0] pBot = $signed(req.a[15:0]) * $signed(bx[15:0]);
   wire signed [31:0] pTop = $signed(req.a[31:16]) * $signed(bx[31:16]);
   wire signed [32:0] dualSum = {pBot[31], pBot} + {pTop[31], pTop}; // RULE2
   wire signed [32:0] dualDif = {pBot[31], pBot} - {pTop[31], pTop}; // RULE2
   wire signed [47:0] wordProd = $signed(req.a) * hM; // RULE6
   wire [63:0] uProd = {32'h0000_0000, req.a} * {32'h0000_0000, req.b};
   wire signed [63:0] sProd = $signed(req.a) * $signed(req.b);
   // pair registers come from the source, which names them distinctly
   wire [63:0] accPair = {req.accHi, req.accLo}; // RULE11
   wire signed [35:0] aW = {{4{req.a[31]}}, req.a};
   wire signed [35:0] bW = {{4{req.b[31]}}, req.b};
   wire [32:0] dblB = satv(bW + bW, WORD_BITS, 1'b0); // RULE18
   wire signed [35:0] dblW = {{4{dblB[31]}}, dblB[31:0]};
   wire [32:0] saturating_add = satv(aW + bW, WORD_BITS, 1'b0); // RULE18
   wire [32:0] qSub = satv(aW - bW, WORD_BITS, 1'b0);
   wire [32:0] saturating_double_add = satv(aW + dblW, WORD_BITS, 1'b0);
   wire [32:0] qDSub = satv(aW - dblW, WORD_BITS, 1'b0);
   wire [32:0] signed_saturate = satv(aW, req.satN, 1'b0); // RULE14
   wire [32:0] unsigned_saturate = satv(aW, req.satN, 1'b1); // RULE15

   // lane saturating add/sub/exchange; lane results never touch the flag
   logic [31:0] lane16, lane8;
   logic signed [35:0] lx, ly;
   logic lsub;
   logic [32:0] lsv;
   always_comb begin
      lane16 = 32'h0000_0000;
      lane8 = 32'h0000_0000;
      lx = 36'sh0;
      ly = 36'sh0;
      lsub = 1'b0;
      lsv = 33'h0_0000_0000;
      for (int i = 0; i < 2; i++) begin
         lx = req.uns ? {20'h0_0000, req.a[16*i +: 16]}
                      : {{20{req.a[16*i+15]}}, req.a[16*i +: 16]};
         if ((req.op == OP_QASX) || (req.op == OP_QSAX)) begin
            ly = req.uns ? {20'h0_0000, req.b[16*(1-i) +: 16]}
                         : {{20{req.b[16*(1-i)+15]}}, req.b[16*(1-i) +: 16]};
         end else begin
            ly = req.uns ? {20'h0_0000, req.b[16*i +: 16]}
                         : {{20{req.b[16*i+15]}}, req.b[16*i +: 16]};
         end
         lsub = (req.op == OP_QSUB16) || ((req.op == OP_QASX) && (i == 0))
                || ((req.op == OP_QSAX) && (i == 1)); // RULE18
         lsv = satv(lsub ? lx - ly : lx + ly, HALF_BITS, req.uns);
         lane16[16*i +: 16] = lsv[15:0];
      end
      for (int i = 0; i < 4; i++) begin
         lx = req.uns ? {28'h000_0000, req.a[8*i +: 8]}
                      : {{28{req.a[8*i+7]}}, req.a[8*i +: 8]};
         ly = req.uns ? {28'h000_0000, req.b[8*i +: 8]}
                      : {{28{req.b[8*i+7]}}, req.b[8*i +: 8]};
         lsv = satv((req.op == OP_QSUB8) ? lx - ly : lx + ly, BYTE_BITS, req.uns);
         lane8[8*i +: 8] = lsv[7:0];
      end
   end

   // single-cycle result select; only result words leave, never NZCV
   always_comb begin
      rsp_next = '0;
      satHit = 1'b0;
      case (req.op)
         OP_DUAL_ADD: begin
            rsp_next.lo = dualSum[31:0]; // RULE2
            satHit = dualSum[32] != dualSum[31]; // RULE1
         end
         OP_DUAL_SUB: rsp_next.lo = dualDif[31:0];
         OP_HALF_MUL: rsp_next.lo = halfProd; // RULE5
         OP_WORD_MUL: rsp_next.lo = wordProd[47:16]; // RULE6
         OP_ULONG_MUL: {rsp_next.hi, rsp_next.lo} = uProd; // RULE7
         OP_SLONG_MUL: {rsp_next.hi, rsp_next.lo} = sProd; // RULE7
         OP_ULONG_MAC: {rsp_next.hi, rsp_next.lo} = uProd + accPair; // RULE8
         OP_SLONG_MAC: {rsp_next.hi, rsp_next.lo} = sProd + accPair; // RULE9
         OP_SIGN_SAT: {satHit, rsp_next.lo} = signed_saturate;
         OP_UNS_SAT: {satHit, rsp_next.lo} = unsigned_saturate;
         OP_SAT_ADD: {satHit, rsp_next.lo} = saturating_add;
         OP_QSUB: {satHit, rsp_next.lo} = qSub;
         OP_SAT_DADD: begin
            rsp_next.lo = saturating_double_add[31:0];
            satHit = dblB[32] | saturating_double_add[32];
         end
         OP_QDSUB: begin
            rsp_next.lo = qDSub[31:0];
            satHit = dblB[32] | qDSub[32];
         end
         OP_QADD16, OP_QSUB16, OP_QASX, OP_QSAX: rsp_next.lo = lane16;
         OP_QADD8, OP_QSUB8: rsp_next.lo = lane8;
         default: rsp_next = '0;
      endcase
      rsp_next.wrHi = (req.op == OP_ULONG_MUL) || (req.op == OP_SLONG_MUL)
                      || (req.op == OP_ULONG_MAC) || (req.op == OP_SLONG_MAC); // RULE10
   end

   // restoring divider step on magnitudes
   wire [32:0] divTrial = {divRem_reg[31:0], divQuo_reg[31]};
   wire [33:0] divDiff = {1'b0, divTrial} - {2'b00, divDen_reg};
   wire divGe = ~divDiff[33];
   wire [31:0] divQuoStep = {divQuo_reg[30:0], divGe};
   // negating the magnitude quotient truncates towards zero
   wire [31:0] divOut = divZero_reg ? 32'h0000_0000
                        : (divNeg_reg ? -divQuoStep : divQuoStep); // RULE12
   wire divEnd = (state_reg == ST_DIV) && (divCnt_reg == DIV_LAST);

   // issue is refused while the divider runs
   assign reqReady = state_reg == ST_IDLE; // RULE19
   assign rspValid = rspValid_reg;
   assign rsp = rsp_reg;

   // sequencer, divider and writeback registers
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
         rspValid_reg <= 1'b0;
         rsp_reg <= '0;
         hold_reg <= '0;
         divRem_reg <= '0;
         divQuo_reg <= '0;
         divDen_reg <= '0;
         divCnt_reg <= '0;
         divNeg_reg <= 1'b0;
         divZero_reg <= 1'b0;
      end else if (ce) begin
         rspValid_reg <= 1'b0;
         if (fire) begin
            hold_reg <= req;
         end
         if (fire && isDiv) begin
            state_reg <= ST_DIV;
            divRem_reg <= '0;
            divQuo_reg <= (sgnDiv && req.a[31]) ? -req.a : req.a;
            divDen_reg <= (sgnDiv && req.b[31]) ? -req.b : req.b;
            divNeg_reg <= sgnDiv && (req.a[31] ^ req.b[31]);
            divZero_reg <= req.b == 32'h0000_0000;
            divCnt_reg <= '0;
         end else if (fire) begin
            rsp_reg <= rsp_next;
            rspValid_reg <= 1'b1;
         end else if (state_reg == ST_DIV) begin
            divRem_reg <= divGe ? divDiff[32:0] : divTrial;
            divQuo_reg <= divQuoStep;
            divCnt_reg <= divCnt_reg + 6'h01;
            if (divEnd) begin
               state_reg <= ST_IDLE;
               rsp_reg <= '{lo: divOut, hi: 32'h0000_0000, wrHi: 1'b0}; // RULE19
               rspValid_reg <= 1'b1; // RULE13
            end
         end
      end
   end

   // AHB-Lite status slave: zero wait, always OKAY, unmapped reads zero
   wire addrPhase = hsel & htrans[1] & hready;
   wire statHit = haddr[7:0] == STATUS_OFS;
   wire wrQ = wrPend_reg & hitStat_reg;
   wire [31:0] statusWord = {30'h0000_0000, ~reqReady, q_reg};
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;
   // sticky flag: saturation set wins over a same-cycle clearing write
   assign q_next = (wrQ ? hwdata[Q_BIT] : q_reg) | (fire & satHit); // RULE16 RULE17
   assign satFlag = q_reg;

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         wrPend_reg <= 1'b0;
         hitStat_reg <= 1'b0;
         hrdata_reg <= 32'h0000_0000;
         q_reg <= Q_RESET; // RULE20
      end else if (ce) begin
         wrPend_reg <= addrPhase & hwrite & (hsize == HSIZE_WORD);
         hitStat_reg <= statHit;
         if (addrPhase && !hwrite) begin
            hrdata_reg <= statHit ? statusWord : 32'h0000_0000;
         end
         q_reg <= q_next; // RULE20
      end
   end

   default clocking dc @(posedge mclk); endclocking
   default disable iff (!rstn);

   a_dual_add_sum: assert property (rspValid && hold_reg.op == OP_DUAL_ADD // RULE2
      && !hold_reg.xchg |-> rsp.lo == 32'($signed(hold_reg.a[15:0])
      * $signed(hold_reg.b[15:0]) + $signed(hold_reg.a[31:16]) * $signed(hold_reg.b[31:16])))
      else $error("dual add result wrong");
   a_exch_sub_swap: assert property (rspValid && hold_reg.op == OP_DUAL_SUB // RULE3
      && hold_reg.xchg |-> rsp.lo == 32'($signed(hold_reg.a[15:0])
      * $signed(hold_reg.b[31:16]) - $signed(hold_reg.a[31:16]) * $signed(hold_reg.b[15:0])))
      else $error("exchanged dual subtract wrong");
   a_half_top_bot: assert property (rspValid && hold_reg.op == OP_HALF_MUL // RULE4
      && hold_reg.selN && !hold_reg.selM
      |-> rsp.lo == 32'($signed(hold_reg.a[31:16]) * $signed(hold_reg.b[15:0])))
      else $error("halfword multiply selection wrong");
   a_long_unsigned: assert property (rspValid && hold_reg.op == OP_ULONG_MUL // RULE7
      |-> {rsp.hi, rsp.lo} == {32'h0000_0000, hold_reg.a} * {32'h0000_0000, hold_reg.b}
      && rsp.wrHi) else $error("unsigned long product wrong");
   a_div_stall: assert property (fire && isDiv |=> !reqReady [*8]) // RULE19
      else $error("issue accepted during divide");
   a_div_finish: assert property (divEnd && ce |=> rspValid && reqReady) // RULE19
      else $error("divide did not write back");
   a_unsigned_divide_quot: assert property (rspValid && hold_reg.op == OP_UNS_DIV // RULE12
      && hold_reg.b != 32'h0000_0000 |-> rsp.lo == hold_reg.a / hold_reg.b)
      else $error("unsigned quotient wrong");
   a_unsigned_saturate_neg: assert property (rspValid && hold_reg.op == OP_UNS_SAT // RULE15
      && hold_reg.a[31] |-> rsp.lo == 32'h0000_0000) else $error("unsigned clamp not zero");
   a_q_set: assert property (fire && satHit |=> satFlag) // RULE16
      else $error("saturation did not set flag");
   a_q_hold: assert property (satFlag && !wrQ |=> satFlag) // RULE20
      else $error("sticky flag lost");
   // lane operations and the dual subtract must never raise the flag
   a_lane_no_q: assert property (fire && req.op inside {[OP_QADD16:OP_QSAX]} // RULE18
      && !satFlag && !wrQ |=> !satFlag) else $error("lane op raised flag");
   a_sub_no_q: assert property (fire && req.op == OP_DUAL_SUB // RULE2
      && !satFlag && !wrQ |=> !satFlag) else $error("dual subtract raised flag");
   a_q_clear: assert property (ce && wrQ && !hwdata[Q_BIT] // RULE17
      && !(fire && satHit) |=> !satFlag) else $error("status write did not clear flag");
   a_short_hi: assert property (rspValid && !(hold_reg.op inside {[OP_ULONG_MUL:OP_SLONG_MAC]}) // RULE10
      |-> !rsp.wrHi && rsp.hi == 32'h0000_0000) else $error("short op wrote high word");
   a_div_zero: assert property (rspValid && hold_reg.op inside {OP_SIGN_DIV, OP_UNS_DIV} // RULE12
      && hold_reg.b == 32'h0000_0000 |-> rsp.lo == 32'h0000_0000)
      else $error("divide by zero not zero");
   a_signed_saturate_one: assert property (rspValid && hold_reg.op == OP_SIGN_SAT // RULE14
      && hold_reg.satN == 6'h01 |-> rsp.lo inside {32'h0000_0000, 32'hFFFF_FFFF})
      else $error("one-bit signed clamp out of range");

endmodule : mds_datapath

/* File: mds_dec_model.sv */
// decoder side model: offers one operation and holds it until taken
// assumes the bench calls issue and drop right after a rising edge
`timescale 1ns/1ps
module mds_dec_model
   import mds_pkg::*;
(
   input wire logic mclk,
   input wire logic ce,
   input wire logic reqReady,
   output logic reqValid,
   output mds_pkg::mds_req_t req,
   output logic stuck
);
   import mds_pkg::*;
   initial begin
      reqValid = 1'b0;
      req = '0;
      stuck = 1'b0;
   end
   // request stands whole until an enabled edge sees ready; a divide holds it off
   task automatic issue(input mds_req_t r);
      int n;
      reqValid <= 1'b1;
      req <= r;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (!(ce === 1'b1 && reqReady === 1'b1) && n < 200);
      if (n >= 200) stuck <= 1'b1;
   endtask : issue
   // released operands show the inverse, not the last value
   task automatic drop();
      reqValid <= 1'b0;
      req <= ~req;
   endtask : drop
endmodule : mds_dec_model

/* File: tb.sv */
// bench for the datapath: decoder model issues, a monitor scores each result
// assumes one mds_datapath with its status word on AHB-Lite
`timescale 1ns/1ps
module tb;
   import mds_pkg::*;
   typedef struct packed {mds_rsp_t r; logic q;} mds_note_t;
   logic mclk, rstn, ce, reqValid, reqReady, rspValid, satFlag, stuck;
   logic hsel, hwrite, hreadyout, hresp, hit, qExp, tmo, ceRand;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   mds_req_t req, r;
   mds_rsp_t rsp;
   mds_note_t q[$];
   mds_note_t t;
   int seed = 58739;
   int n_mismatch = 0;
   int check_count = 0;
   int k;
   mds_datapath dut (.mclk(mclk), .rstn(rstn), .ce(ce), .reqValid(reqValid),
      .reqReady(reqReady), .req(req), .rspValid(rspValid), .rsp(rsp), .satFlag(satFlag),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata));
   mds_dec_model prt (.mclk(mclk), .ce(ce), .reqReady(reqReady), .reqValid(reqValid),
      .req(req), .stuck(stuck));
   task automatic end_sim();
      if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   // clamps note any change in hit; the caller decides if it is sticky
   function automatic longint ss(input longint x, input int n);
      longint m;
      m = (longint'(1) <<< (n - 1)) - 1;
      hit |= (x > m) || (x < -m - 1);
      return (x > m) ? m : (x < -m - 1) ? -m - 1 : x;
   endfunction : ss
   function automatic longint us(input longint x, input int n);
      longint m;
      m = (longint'(1) <<< n) - 1;
      hit |= (x > m) || (x < 0);
      return (x > m) ? m : (x < 0) ? 0 : x;
   endfunction : us
   function automatic longint ln(input longint p, input longint s, input int w,
      input logic u, input logic d);
      if (!u) p = (p <<< (64 - w)) >>> (64 - w);
      if (!u) s = (s <<< (64 - w)) >>> (64 - w);
      p = d ? p - s : p + s;
      return u ? us(p, w) : ss(p, w);
   endfunction : ln
   // expected result and sticky flag of one operation
   function automatic mds_note_t model(input mds_req_t r);
      mds_note_t n;
      logic [31:0] b;
      longint p0, p1, ha, hb, sa, sb, x;
      b = r.xchg ? {r.b[15:0], r.b[31:16]} : r.b;
      p0 = $signed(r.a[15:0]) * $signed(b[15:0]);
      p1 = $signed(r.a[31:16]) * $signed(b[31:16]);
      ha = r.selN ? $signed(r.a[31:16]) : $signed(r.a[15:0]);
      hb = r.selM ? $signed(r.b[31:16]) : $signed(r.b[15:0]);
      sa = $signed(r.a);
      sb = $signed(r.b);
      hit = 1'b0;
      x = 0;
      n = '0;
      case (r.op)
         OP_DUAL_ADD: x = p0 + p1 + 0 * ss(p0 + p1, 32);
         OP_DUAL_SUB: x = p0 - p1;
         OP_HALF_MUL: x = ha * hb;
         OP_WORD_MUL: x = (sa * hb) >>> 16;
         OP_ULONG_MUL: x = {32'h0, r.a} * {32'h0, r.b};
         OP_ULONG_MAC: x = {32'h0, r.a} * {32'h0, r.b} + {r.accHi, r.accLo};
         OP_SLONG_MUL: x = sa * sb;
         OP_SLONG_MAC: x = sa * sb + $signed({r.accHi, r.accLo});
         OP_SIGN_DIV: x = (r.b == 0) ? 0 : (r.b == '1 && r.a == 32'h8000_0000) ? sa : sa / sb;
         OP_UNS_DIV: x = (r.b == 0) ? 0 : r.a / r.b;
         OP_SIGN_SAT: x = ss(sa, r.satN);
         OP_UNS_SAT: x = us(sa, r.satN);
         OP_SAT_ADD: x = ss(sa + sb, 32);
         OP_QSUB: x = ss(sa - sb, 32);
         OP_SAT_DADD: x = ss(sa + ss(2 * sb, 32), 32);
         OP_QDSUB: x = ss(sa - ss(2 * sb, 32), 32);
         OP_QADD16, OP_QSUB16, OP_QASX, OP_QSAX: for (int i = 0; i < 2; i++)
            x[i*16+:16] = 16'(ln(r.a[i*16+:16], (r.op inside {OP_QASX, OP_QSAX})
               ? r.b[(1-i)*16+:16] : r.b[i*16+:16], 16, r.uns, (r.op == OP_QSUB16)
               || (r.op == OP_QASX && i == 0) || (r.op == OP_QSAX && i == 1)));
         default: for (int i = 0; i < 4; i++)
            x[i*8+:8] = 8'(ln(r.a[i*8+:8], r.b[i*8+:8], 8, r.uns, r.op == OP_QSUB8));
      endcase
      if (!(r.op inside {[OP_QADD16:OP_QSAX]})) qExp |= hit; // lane ops never stick
      n.r.lo = x[31:0];
      n.r.wrHi = r.op inside {OP_ULONG_MUL, OP_ULONG_MAC, OP_SLONG_MUL, OP_SLONG_MAC};
      n.r.hi = n.r.wrHi ? x[63:32] : 32'h0;
      n.q = qExp;
      return n;
   endfunction : model
   task automatic run_op(input mds_req_t x);
      q.push_back(model(x));
      prt.issue(x);
   endtask : run_op
   task automatic go(input mds_op_t o, input logic [31:0] a, input logic [31:0] b);
      r.op = o;
      r.a = a;
      r.b = b;
      run_op(r);
   endtask : go
   task automatic hwait();
      int n;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20) tmo = 1'b1;
   endtask : hwait
   // address phase, then data phase; read data taken at its closing edge
   task automatic ahb(input logic w, input logic [31:0] ad, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= ad;
      hwrite <= w;
      hsize <= HSIZE_WORD;
      hwait();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      hwait();
      rd = hrdata;
      chk("hresp", hresp, 1'b0);
   endtask : ahb
   task automatic drain();
      int n;
      n = 0;
      while (q.size() > 0 && n < 100) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 100) tmo = 1'b1;
   endtask : drain
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // random clock enable in the random phase only
   always @(posedge mclk) ce <= ceRand ? (($random(seed) & 3) != 0) : 1'b1;
   // any hang ends the run as a failure
   always @(posedge mclk) if (tmo === 1'b1 || stuck === 1'b1) begin
      n_mismatch++;
      end_sim();
   end
   // score each result once, at the falling edge before the enabled edge that ends its pulse
   always @(negedge mclk) if (rspValid === 1'b1 && ce === 1'b1) begin
      if (q.size() == 0) chk("extra", 1'b1, 1'b0);
      else begin
         t = q.pop_front();
         chk("lo", rsp.lo, t.r.lo);
         chk("hi", rsp.hi, t.r.hi);
         chk("wrHi", rsp.wrHi, t.r.wrHi);
         chk("sat", satFlag, t.q);
      end
   end
   initial begin
      {rstn, hsel, hwrite, tmo, qExp, hit, ceRand} = '0;
      {haddr, hwdata, htrans, hsize} = '0;
      ce = 1'b1;
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      ahb(1'b0, {24'h0, STATUS_OFS}, 32'h0);
      chk("status", rd, 32'h0);
      ahb(1'b0, 32'h0000_0040, 32'h0);
      chk("unmapped", rd, 32'h0);
      r = '0;
      go(OP_DUAL_ADD, 32'h8000_8000, 32'h8000_8000);
      prt.drop();
      drain();
      ahb(1'b1, 32'h0000_0040, 32'h0);
      ahb(1'b0, {24'h0, STATUS_OFS}, 32'h0);
      chk("status", rd, 32'h1);
      ahb(1'b1, {24'h0, STATUS_OFS}, 32'h0);
      qExp = 1'b0;
      ahb(1'b0, {24'h0, STATUS_OFS}, 32'h0);
      chk("status", rd, 32'h0);
      for (int i = 0; i < 4; i++) begin
         {r.selN, r.selM} = 2'(i);
         go(OP_HALF_MUL, 32'h8000_0003, 32'hFFFE_7FFF);
      end
      r.xchg = 1'b1;
      r.satN = 6'h04;
      go(OP_DUAL_SUB, 32'h0002_0003, 32'h0005_0007);
      go(OP_SIGN_DIV, 32'hFFFF_FFF9, 32'h0000_0002);
      go(OP_SIGN_SAT, 32'hFFFF_FFF0, 32'h0);
      go(OP_UNS_DIV, 32'h0000_0007, 32'h0);
      go(OP_UNS_SAT, 32'h0000_0020, 32'h0);
      ceRand <= 1'b1;
      repeat (300) begin
         k = $unsigned($random(seed)) % 22;
         r.op = mds_op_t'(k);
         r.a = $random(seed);
         r.b = $random(seed);
         r.accHi = $random(seed);
         r.accLo = $random(seed);
         {r.xchg, r.selN, r.selM, r.uns} = 4'($random(seed));
         r.satN = 6'($unsigned($random(seed)) % 32 + (r.op == OP_SIGN_SAT));
         run_op(r);
      end
      ceRand <= 1'b0;
      prt.drop();
      drain();
      ahb(1'b0, {24'h0, STATUS_OFS}, 32'h0);
      chk("status", rd, {31'h0, qExp});
      end_sim();
   end
endmodule : tb
